// ===== sdac_top.sv
// stereo dac front end: power-up sequencing, mode selection, clock ratio check
// assumes the host register port and all pins are synchronous to i_core_clk
`timescale 1ns/1ns
`default_nettype none
`include "sdac_defines.svh"
module sdac_top
   import sdac_pkg::*;
#(
   parameter int unsigned CP_WIN_CYC = `SDAC_CP_WIN_MS * 1000 * `SDAC_CLK_MHZ,
   parameter int unsigned PWRUP_CYC = `SDAC_PWRUP_US * `SDAC_CLK_MHZ
)(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_mode_pin_0,
   input wire logic i_mode_pin_1,
   input wire logic i_mode_pin_2,
   input wire logic i_mode_pin_3,
   input wire logic i_bitstream_mode_select,
   input wire logic i_bit_clock,
   input wire logic i_frame_clock,
   input wire logic i_serial_audio_in,
   input wire logic i_bitstream_bit_clock,
   input wire logic i_bitstream_data_a,
   input wire logic i_bitstream_data_b,
   output logic o_reference_output,
   output logic o_mute_a,
   output logic o_mute_b,
   output logic o_ctrl_port_mode,
   output logic o_running,
   output sdac_cfg_s o_cfg,
   output logic [7:0] o_oversample,
   output sdac_frame_s o_frame,
   output logic o_frame_valid,
   output logic [1:0] o_bits,
   output logic o_bits_valid
);
   // ***********************
   // power sequencing
   // ***********************
   typedef enum logic [2:0] {SDAC_WAIT, SDAC_LOWPWR, SDAC_PWRUP, SDAC_RUN} sdac_state_e;
   sdac_state_e st_ff, nxt_st;
   logic [31:0] win_ff, nxt_win;
   logic [15:0] pu_ff, nxt_pu;
   logic cp_ff, nxt_cp;
   logic [7:0] r05_ff, nxt_r05, r01_ff, nxt_r01, r02_ff, nxt_r02, r06_ff, nxt_r06;
   logic [7:0] rd_ff, nxt_rd;
   logic cp_write, win_done, power_down_bit;
   // unlock value or enable bit both select the control port
   assign cp_write = i_wr && (i_addr == `SDAC_CP_ADDR) && ((i_wdata == `SDAC_CP_VAL) || i_wdata[`SDAC_CTRL_PORT_ENABLE_BIT_BIT]);
   assign win_done = (win_ff >= CP_WIN_CYC - 1);
   assign power_down_bit = r05_ff[`SDAC_PDN_BIT];
   always_comb begin
      nxt_st = st_ff;
      nxt_win = win_ff;
      nxt_pu = pu_ff;
      nxt_cp = cp_ff;
      unique case (st_ff)
         SDAC_WAIT: begin
            if (cp_write) begin
               nxt_cp = 1'b1;
               nxt_st = SDAC_LOWPWR;
            end else if (win_done) begin
               nxt_st = SDAC_RUN;
            end else begin
               nxt_win = win_ff + 32'h1;
            end
         end
         SDAC_LOWPWR: begin
            // stay low power while pdn set
            if (!power_down_bit) begin
               nxt_st = SDAC_PWRUP;
               nxt_pu = 16'h0;
            end
         end
         SDAC_PWRUP: begin
            if (power_down_bit) nxt_st = SDAC_LOWPWR;
            else if (pu_ff >= 16'(PWRUP_CYC - 1)) nxt_st = SDAC_RUN;
            else nxt_pu = pu_ff + 16'h1;
         end
         SDAC_RUN: begin
            if (cp_write && !cp_ff) begin
               nxt_cp = 1'b1;
               nxt_st = SDAC_LOWPWR;
            end else if (cp_ff && power_down_bit) begin
               nxt_st = SDAC_LOWPWR;
            end
         end
         default: nxt_st = SDAC_WAIT;
      endcase
   end
   // ***********************
   // register port
   // ***********************
   always_comb begin
      nxt_r05 = r05_ff;
      nxt_r01 = r01_ff;
      nxt_r02 = r02_ff;
      nxt_r06 = r06_ff;
      nxt_rd = `SDAC_ZERO8;
      if (i_wr) begin
         unique case (i_addr)
            `SDAC_CP_ADDR: nxt_r05 = i_wdata;
            `SDAC_MC1_ADDR: nxt_r01 = i_wdata;
            `SDAC_MC2_ADDR: nxt_r02 = i_wdata;
            `SDAC_MC3_ADDR: nxt_r06 = i_wdata;
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            `SDAC_CP_ADDR: nxt_rd = r05_ff;
            `SDAC_MC1_ADDR: nxt_rd = r01_ff;
            `SDAC_MC2_ADDR: nxt_rd = r02_ff;
            `SDAC_MC3_ADDR: nxt_rd = r06_ff;
            `SDAC_STAT_ADDR: nxt_rd = {3'h0, o_mute_a, o_running, cp_ff, 2'(st_ff)};
            default: nxt_rd = `SDAC_ZERO8;
         endcase
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_ff <= SDAC_WAIT;
         win_ff <= 32'h0;
         pu_ff <= 16'h0;
         cp_ff <= 1'b0;
         r05_ff <= `SDAC_PDN_RST;
         r01_ff <= `SDAC_ZERO8;
         r02_ff <= `SDAC_ZERO8;
         r06_ff <= `SDAC_ZERO8;
         rd_ff <= `SDAC_ZERO8;
      end else begin
         st_ff <= nxt_st;
         win_ff <= nxt_win;
         pu_ff <= nxt_pu;
         cp_ff <= nxt_cp;
         r05_ff <= nxt_r05;
         r01_ff <= nxt_r01;
         r02_ff <= nxt_r02;
         r06_ff <= nxt_r06;
         rd_ff <= nxt_rd;
      end
   end
   assign o_rdata = rd_ff;
   // ***********************
   // mode selection
   // ***********************
   sdac_cfg_s cfg;
   sdac_fmt_e fmt_cp;
   always_comb begin
      cfg = '0;
      fmt_cp = SDAC_LJ;
      if (cp_ff) begin
         unique case (r01_ff[`SDAC_FM_LSB +: 2])
            2'h0: cfg.speed = SDAC_SINGLE;
            2'h1: cfg.speed = SDAC_DOUBLE;
            2'h2: cfg.speed = SDAC_QUAD;
            default: cfg.speed = SDAC_BITSTREAM;
         endcase
         // rj20 and rj18 in control port only
         if (r01_ff[`SDAC_DIF_LSB +: 3] <= 3'h5) fmt_cp = sdac_fmt_e'(r01_ff[`SDAC_DIF_LSB +: 3]);
         cfg.fmt = fmt_cp;
         cfg.slow_filter = r06_ff[`SDAC_REFERENCE_OUTPUT_BIT];
         cfg.mclk_div = r02_ff[`SDAC_MDIV_BIT];
         cfg.deemph = r02_ff[`SDAC_DEM_BIT];
      end else begin
         if (i_bitstream_mode_select) cfg.speed = SDAC_BITSTREAM;
         else cfg.speed = i_mode_pin_3 ? (i_mode_pin_2 ? SDAC_QUAD : SDAC_DOUBLE) : SDAC_SINGLE;
         cfg.fmt = sdac_fmt_e'({1'b0, i_mode_pin_1, i_mode_pin_0});
         cfg.slow_filter = 1'b0;
         cfg.deemph = ~i_mode_pin_3 & i_mode_pin_2;
         cfg.mclk_div = 1'b0;
      end
      // curve tracks the frame rate since it runs per sample
      if (cfg.speed != SDAC_SINGLE) cfg.deemph = 1'b0;
   end
   assign o_oversample = (cfg.speed == SDAC_SINGLE) ? 8'h80 : (cfg.speed == SDAC_DOUBLE) ? 8'h40 : 8'h20;
   // ***********************
   // ratio check
   // ***********************
   logic lr_ff, nxt_lr;
   logic [11:0] mc_ff, nxt_mc, ratio_ff, nxt_ratio;
   logic ok;
   // core clocks counted from one rising frame clock edge to the next, saturating at 4095
   always_comb begin
      nxt_lr = i_frame_clock;
      nxt_mc = (mc_ff == 12'hFFF) ? mc_ff : mc_ff + 12'h1;
      nxt_ratio = ratio_ff;
      if (i_frame_clock && !lr_ff) begin
         nxt_ratio = mc_ff + 12'h1;
         nxt_mc = 12'h0;
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         lr_ff <= 1'b0;
         mc_ff <= 12'h0;
         ratio_ff <= 12'h0;
      end else begin
         lr_ff <= nxt_lr;
         mc_ff <= nxt_mc;
         ratio_ff <= nxt_ratio;
      end
   end
   always_comb begin
      ok = 1'b0;
      unique case (cfg.speed)
         SDAC_SINGLE: ok = (ratio_ff == 12'd256) || (ratio_ff == 12'd384) || (ratio_ff == 12'd512) ||
                           (ratio_ff == 12'd768) || (ratio_ff == 12'd1024 && cfg.mclk_div);
         SDAC_DOUBLE: ok = (ratio_ff == 12'd128) || (ratio_ff == 12'd192) || (ratio_ff == 12'd256) ||
                           (ratio_ff == 12'd384) || (ratio_ff == 12'd512 && cfg.mclk_div);
         SDAC_QUAD: ok = (ratio_ff == 12'd64) || (ratio_ff == 12'd96) || (ratio_ff == 12'd128) ||
                         (ratio_ff == 12'd192) || (ratio_ff == 12'd256 && cfg.mclk_div);
         default: ok = 1'b1;
      endcase
   end
   // ***********************
   // outputs
   // ***********************
   assign o_running = (st_ff == SDAC_RUN);
   assign o_reference_output = o_running;
   assign o_mute_a = ~o_running | ~ok;
   assign o_mute_b = o_mute_a;
   assign o_ctrl_port_mode = cp_ff;
   assign o_cfg = cfg;
   sdac_serial_rx u_rx (
      .i_core_clk(i_core_clk),
      .i_rstn(i_rstn),
      .i_enable(o_running),
      .i_fmt(cfg.fmt),
      .i_bitstream(cfg.speed == SDAC_BITSTREAM),
      .i_bit_clock((cfg.speed == SDAC_BITSTREAM) ? i_bitstream_bit_clock : i_bit_clock),
      .i_frame_clock(i_frame_clock),
      .i_serial_audio_in(i_serial_audio_in),
      .i_bitstream_data_a(i_bitstream_data_a),
      .i_bitstream_data_b(i_bitstream_data_b),
      .o_frame(o_frame),
      .o_frame_valid(o_frame_valid),
      .o_bits(o_bits),
      .o_bits_valid(o_bits_valid)
   );
   // ***********************
   // assertions
   // ***********************
   a_ref_low_pdn: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (cp_ff && power_down_bit) |-> ##1 !o_reference_output) else $error("reference up while powered down");
   a_mute_bad_ratio: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !ok |-> o_mute_a && o_mute_b) else $error("no mute on bad ratio");
   a_fast_filter: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !cp_ff |-> !o_cfg.slow_filter) else $error("slow filter in stand-alone");
   a_deemph_single: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      o_cfg.deemph |-> o_cfg.speed == SDAC_SINGLE) else $error("de-emphasis off single speed");
   a_cp_enter: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (st_ff == SDAC_WAIT && cp_write) |=> cp_ff && !o_running) else $error("enable write not taken");
   a_pwrup_start: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (st_ff == SDAC_LOWPWR && !power_down_bit) |=> st_ff == SDAC_PWRUP) else $error("power-up not started");
   a_late_enable: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      (o_running && !cp_ff && cp_write) |=> cp_ff) else $error("late enable lost");
   a_standalone_fmt: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      !cp_ff |-> o_cfg.fmt == sdac_fmt_e'({1'b0, i_mode_pin_1, i_mode_pin_0})) else $error("format pins ignored");
   a_low_after_rst: assert property (@(posedge i_core_clk) disable iff (!i_rstn)
      $rose(i_rstn) |-> !o_reference_output) else $error("reference high at release");
endmodule : sdac_top
`default_nettype wire

// ===== sdac_defines.svh
// constants for the stereo dac audio input and configuration block
// assumes a 100 MHz core clock
`ifndef SDAC_DEFINES_SVH
`define SDAC_DEFINES_SVH
`define SDAC_CLK_MHZ 100
`define SDAC_CP_WIN_MS 10
`define SDAC_PWRUP_US 10
`define SDAC_CP_ADDR 8'h05
`define SDAC_CP_VAL 8'h30
`define SDAC_CTRL_PORT_ENABLE_BIT_BIT 7
`define SDAC_PDN_BIT 0
`define SDAC_MC3_ADDR 8'h06
`define SDAC_REFERENCE_OUTPUT_BIT 5
`define SDAC_MC1_ADDR 8'h01
`define SDAC_MC2_ADDR 8'h02
`define SDAC_RATIO_ADDR 8'h07
`define SDAC_STAT_ADDR 8'h08
`define SDAC_PDN_RST 8'h01
`define SDAC_ZERO8 8'h00
`define SDAC_DIF_LSB 4
`define SDAC_FM_LSB 0
`define SDAC_MDIV_BIT 4
`define SDAC_DEM_BIT 2
`endif

// ===== sdac_pkg.sv
// shared types for the stereo dac input block
// assumes sdac_defines.svh is in the include path
package sdac_pkg;
   typedef enum logic [1:0] {SDAC_SINGLE, SDAC_DOUBLE, SDAC_QUAD, SDAC_BITSTREAM} sdac_speed_e;
   typedef enum logic [2:0] {SDAC_LJ, SDAC_I2S, SDAC_RJ16, SDAC_RJ24, SDAC_RJ20, SDAC_RJ18} sdac_fmt_e;
   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
   } sdac_frame_s;
   typedef struct packed {
      sdac_speed_e speed;
      sdac_fmt_e fmt;
      logic slow_filter;
      logic deemph;
      logic mclk_div;
   } sdac_cfg_s;
endpackage : sdac_pkg

// ===== sdac_serial_rx.sv
// serial pcm and one-bit bitstream receiver
// assumes all serial inputs are sampled by the core clock
`timescale 1ns/1ns
`default_nettype none
`include "sdac_defines.svh"
module sdac_serial_rx
   import sdac_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_enable,
   input wire sdac_fmt_e i_fmt,
   input wire logic i_bitstream,
   input wire logic i_bit_clock,
   input wire logic i_frame_clock,
   input wire logic i_serial_audio_in,
   input wire logic i_bitstream_data_a,
   input wire logic i_bitstream_data_b,
   output sdac_frame_s o_frame,
   output logic o_frame_valid,
   output logic [1:0] o_bits,
   output logic o_bits_valid
);
   // ***********************
   // edge detection
   // ***********************
   logic bclk_ff, frame_clock_ff, nxt_bclk, nxt_frame_clock;
   logic [47:0] sh_ff, nxt_sh;
   logic [5:0] cnt_ff, nxt_cnt;
   sdac_frame_s frame_ff, nxt_frame;
   logic fv_ff, nxt_fv, bv_ff, nxt_bv;
   logic [1:0] bits_ff, nxt_bits;
   logic rise, lr_edge;
   function automatic logic [23:0] sdac_align(input logic [47:0] s, input logic [5:0] n, input sdac_fmt_e f);
      logic [23:0] r;
      r = 24'h000000;
      unique case (f)
         SDAC_RJ16: r = {s[15:0], 8'h00};
         SDAC_RJ18: r = {s[17:0], 6'h00};
         SDAC_RJ20: r = {s[19:0], 4'h0};
         SDAC_RJ24: r = s[23:0];
         default: r = (n >= 6'h18) ? s[n - 6'h01 -: 24] : 24'(s << (6'h18 - n));
      endcase
      return r;
   endfunction : sdac_align
   assign rise = i_bit_clock & ~bclk_ff;
   assign lr_edge = i_frame_clock ^ frame_clock_ff;
   // ***********************
   // capture
   // ***********************
   always_comb begin
      nxt_bclk = i_bit_clock;
      nxt_frame_clock = frame_clock_ff;
      nxt_sh = sh_ff;
      nxt_cnt = cnt_ff;
      nxt_frame = frame_ff;
      nxt_fv = 1'b0;
      nxt_bv = 1'b0;
      nxt_bits = bits_ff;
      if (i_enable && rise) begin
         if (i_bitstream) begin
            nxt_bits = {i_bitstream_data_a, i_bitstream_data_b};
            nxt_bv = 1'b1;
         end else begin
            nxt_frame_clock = i_frame_clock;
            if (lr_edge) begin
               // left word rides frame high, or frame low in i2s
               if (frame_clock_ff != (i_fmt == SDAC_I2S)) begin
                  nxt_frame.left = sdac_align(sh_ff, cnt_ff, i_fmt);
               end else begin
                  nxt_frame.right = sdac_align(sh_ff, cnt_ff, i_fmt);
                  nxt_fv = 1'b1;
               end
               // i2s msb lands one bit clock after the edge
               nxt_cnt = (i_fmt == SDAC_I2S) ? 6'h00 : 6'h01;
               nxt_sh = (i_fmt == SDAC_I2S) ? 48'h0 : {47'h0, i_serial_audio_in};
            end else begin
               nxt_sh = {sh_ff[46:0], i_serial_audio_in};
               if (cnt_ff != 6'h30) nxt_cnt = cnt_ff + 6'h01;
            end
         end
      end
   end
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         bclk_ff <= 1'b0;
         frame_clock_ff <= 1'b0;
         sh_ff <= 48'h0;
         cnt_ff <= 6'h00;
         frame_ff <= '0;
         fv_ff <= 1'b0;
         bv_ff <= 1'b0;
         bits_ff <= 2'h0;
      end else begin
         bclk_ff <= nxt_bclk;
         frame_clock_ff <= nxt_frame_clock;
         sh_ff <= nxt_sh;
         cnt_ff <= nxt_cnt;
         frame_ff <= nxt_frame;
         fv_ff <= nxt_fv;
         bv_ff <= nxt_bv;
         bits_ff <= nxt_bits;
      end
   end
   assign o_frame = frame_ff;
   assign o_frame_valid = fv_ff;
   assign o_bits = bits_ff;
   assign o_bits_valid = bv_ff;
endmodule : sdac_serial_rx
`default_nettype wire

// ===== sdac_audio_src.sv
// audio source model: pcm serial stream and bitstream pins
// assumes the core clock samples these pins, clocks stand still when idle
`timescale 1ns/1ns
`default_nettype none
module sdac_audio_src (
   input wire logic i_core_clk,
   input wire logic i_rstn,
   input wire logic i_run,
   input wire logic [3:0] i_bit_half,
   input wire logic [23:0] i_left,
   input wire logic [23:0] i_right,
   output logic o_bit_clock,
   output logic o_frame_clock,
   output logic o_serial_audio_in,
   output logic o_bs_a,
   output logic o_bs_b
);
   // ****************
   // slot timing
   // ****************
   logic [4:0] ph_ff;
   logic [5:0] slot_ff;
   logic [4:0] idx;
   logic [23:0] word;
   always_ff @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         ph_ff <= 5'h00;
         slot_ff <= 6'h00;
      end else if (!i_run || ph_ff == {i_bit_half, 1'b0} - 5'h01) begin
         ph_ff <= 5'h00;
         slot_ff <= i_run ? slot_ff + 6'h01 : 6'h00;
      end else begin
         ph_ff <= ph_ff + 5'h01;
      end
   end
   assign idx = slot_ff[4:0];
   assign word = slot_ff[5] ? i_right : i_left;
   assign o_frame_clock = i_run & ~slot_ff[5];
   assign o_bit_clock = i_run & (ph_ff >= {1'b0, i_bit_half});
   assign o_serial_audio_in = i_run & (idx >= 5'h08) & word[5'h1F - idx];
   assign o_bs_a = i_run & i_left[slot_ff[3:0]];
   assign o_bs_b = i_run & i_right[slot_ff[3:0]];
endmodule : sdac_audio_src
`default_nettype wire

// ===== test_sdac_top.sv
// self-checking testbench for the stereo dac front end
// assumes sdac_audio_src drives the serial and bitstream pins
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, (a), (e)); end end
module test_sdac_top
   import sdac_pkg::*;
;
   logic clk, rstn, wr, rd, run, bsel, refo, mute_a, mute_b, cpm, running, fv, bv;
   logic [7:0] addr, wdata, rdat, rdata, os;
   logic [3:0] mp, half;
   logic [23:0] left, right;
   logic [1:0] bits;
   sdac_cfg_s cfg;
   sdac_frame_s frm;
   int bad_count, n_checks, cyc, rel;
   wire bclk, fclk, sdat, bsa, bsb;
   sdac_top #(.CP_WIN_CYC(200), .PWRUP_CYC(20)) dut (
      .i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_mode_pin_0(mp[0]), .i_mode_pin_1(mp[1]), .i_mode_pin_2(mp[2]), .i_mode_pin_3(mp[3]),
      .i_bitstream_mode_select(bsel), .i_bit_clock(bclk), .i_frame_clock(fclk), .i_serial_audio_in(sdat),
      .i_bitstream_bit_clock(bclk), .i_bitstream_data_a(bsa), .i_bitstream_data_b(bsb),
      .o_reference_output(refo), .o_mute_a(mute_a), .o_mute_b(mute_b), .o_ctrl_port_mode(cpm),
      .o_running(running), .o_cfg(cfg), .o_oversample(os), .o_frame(frm), .o_frame_valid(fv),
      .o_bits(bits), .o_bits_valid(bv));
   sdac_audio_src src (
      .i_core_clk(clk), .i_rstn(rstn), .i_run(run), .i_bit_half(half), .i_left(left), .i_right(right),
      .o_bit_clock(bclk), .o_frame_clock(fclk), .o_serial_audio_in(sdat), .o_bs_a(bsa), .o_bs_b(bsb));
   // ****************
   // tasks and expectations
   // ****************
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : test_done
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask : tick
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      d = rdata;
   endtask : rd_reg
   task automatic wait_for(input int sel, input int lim);
      for (int j = 0; j < lim; j++) begin
         tick(1);
         if ((sel == 0 && fv === 1'b1) || (sel == 1 && bv === 1'b1) || (sel == 2 && running === 1'b1)) break;
      end
   endtask : wait_for
   task automatic do_reset();
      @(posedge clk);
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      `CHK(refo, 1'b0)
      `CHK(mute_a, 1'b1)
      `CHK(rdata, 8'h00)
      @(posedge clk);
      rstn <= 1'b1;
      rel = cyc;
   endtask : do_reset
   function automatic sdac_speed_e exp_speed(input logic [3:0] m, input logic b);
      if (b) return SDAC_BITSTREAM;
      if (!m[3]) return SDAC_SINGLE;
      return m[2] ? SDAC_QUAD : SDAC_DOUBLE;
   endfunction : exp_speed
   function automatic logic [7:0] exp_os(input sdac_speed_e s);
      return (s == SDAC_QUAD) ? 8'h20 : (s == SDAC_DOUBLE) ? 8'h40 : 8'h80;
   endfunction : exp_os
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      rstn = 1'b0;
      {wr, rd, run, bsel} = 4'h0;
      {addr, wdata} = 16'h0000;
      mp = 4'h3;
      half = 4'h2;
      {left, right} = 48'h0;
      {bad_count, n_checks, cyc, rel} = {32'h0, 32'h0, 32'h0, 32'h0};
      void'($urandom(32'h569B));
      do_reset();
      rd_reg(8'h05, rdat); `CHK(rdat, 8'h01)
      rd_reg(8'h06, rdat); `CHK(rdat, 8'h00)
      rd_reg(8'h3C, rdat); `CHK(rdat, 8'h00)
      `CHK(refo, 1'b0)
      wait_for(2, 400);
      `CHK((cyc - rel) inside {[195:235]}, 1'b1)
      `CHK(refo, 1'b1)
      `CHK(cpm, 1'b0)
      `CHK(cfg.slow_filter, 1'b0)
      for (int i = 0; i < 32; i++) begin
         mp <= i[3:0];
         bsel <= i[4];
         tick(3);
         `CHK(cfg.speed, exp_speed(mp, bsel))
         if (!bsel) begin
            `CHK(cfg.fmt, sdac_fmt_e'({1'b0, mp[1:0]}))
            `CHK(cfg.deemph, mp[3:2] == 2'b01)
            `CHK(os, exp_os(exp_speed(mp, 1'b0)))
         end
      end
      mp <= 4'h3;
      bsel <= 1'b0;
      left <= 24'($urandom());
      right <= 24'($urandom());
      run <= 1'b1;
      repeat (3) wait_for(0, 600);
      `CHK(frm, {left, right})
      `CHK(mute_a, 1'b0)
      `CHK(mute_b, 1'b0)
      half <= 4'h1;
      tick(800);
      `CHK(mute_b, 1'b1)
      mp <= 4'hB;
      tick(3);
      `CHK(mute_a, 1'b0)
      mp <= 4'hF;
      tick(3);
      `CHK(mute_a, 1'b0)
      half <= 4'h2;
      tick(800);
      `CHK(mute_a, 1'b1)
      run <= 1'b0;
      $display("test stand-alone done");
      do_reset();
      wr_reg(8'h05, 8'h30);
      wr_reg(8'h05, 8'h81);
      tick(250);
      `CHK(cpm, 1'b1)
      `CHK(running, 1'b0)
      `CHK(refo, 1'b0)
      wr_reg(8'h02, 8'h04);
      wr_reg(8'h06, 8'h20);
      for (int f = 0; f < 6; f++) begin
         wr_reg(8'h01, {1'b0, f[2:0], 4'h1});
         tick(2);
         `CHK(cfg.fmt, sdac_fmt_e'(f[2:0]))
         `CHK(cfg.deemph, 1'b0)
      end
      `CHK(cfg.slow_filter, 1'b1)
      `CHK(os, 8'h40)
      rd_reg(8'h06, rdat); `CHK(rdat, 8'h20)
      wr_reg(8'h01, 8'h00);
      tick(2);
      `CHK(cfg.deemph, 1'b1)
      `CHK(running, 1'b0)
      wr_reg(8'h05, 8'h80);
      rel = cyc;
      wait_for(2, 100);
      `CHK((cyc - rel) inside {[18:28]}, 1'b1)
      `CHK(refo, 1'b1)
      wr_reg(8'h01, 8'h03);
      half <= 4'h8;
      left <= 24'($urandom());
      right <= 24'($urandom());
      run <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         wait_for(1, 100);
         `CHK(bits, {bsa, bsb})
      end
      run <= 1'b0;
      $display("test control port done");
      do_reset();
      wait_for(2, 400);
      wr_reg(8'h05, 8'h81);
      tick(2);
      `CHK(cpm, 1'b1)
      $display("test late enable done");
      test_done();
   end
endmodule : test_sdac_top
`default_nettype wire
